// ### rtl/backlight_config_and_boost_ctrl.sv
// Configuration store with shadow, PWM rate decode, thermal derating and boost control
`timescale 1ns/100ps
module backlight_config_and_boost_ctrl #(
    parameter int N_STRINGS = 7,
    parameter int PWM_W = 8,
    parameter int NVM_OP_CYCLES = 16
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic ext_pwm_in,
    input wire logic chip_en_in,
    input wire logic [bl_cfg_pkg::TEMP_W-1:0] temp_in,
    input wire logic [PWM_W-1:0] led_pwm_in,
    output logic [PWM_W-1:0] led_pwm_out,
    input wire logic [7:0] fault_event_in,
    output logic fault_pin_out,
    output logic fault_pin_oe_out,
    input wire logic boost_up_in,
    input wire logic boost_down_in,
    output logic boost_run_out,
    output logic boost_fast_out,
    output logic [6:0] boost_vout_out,
    output logic phase_shift_pwm_out,
    output logic [bl_cfg_pkg::FREQ_W-1:0] pwm_rate_hz_out,
    output logic [bl_cfg_pkg::FREQ_W-1:0] shift_rate_hz_out,
    output logic store_ready_out
);
    import bl_cfg_pkg::*;

    function automatic logic has_work(input logic [4:0] idx);
        has_work = !((idx >= NOREG_A_LO && idx <= NOREG_A_HI) || (idx >= NOREG_B_LO && idx <= NOREG_B_HI));
    endfunction

    store_state_t state;
    logic [7:0] nvm [32];
    logic [7:0] shadow [32];
    logic [7:0] work [32];
    logic run, boost_on, adapt;
    logic [4:0] boost_out;
    logic st_erase, st_prog, st_reload, st_update;
    logic erased;
    logic [7:0] fault_stat;
    logic [TEMP_FRAC_BITS-1:0] temp_lo;
    logic [15:0] op_cnt;
    logic run_q, adapt_q;
    logic [6:0] vq;

    logic acc_ok, sh_wr, store_wr, ctrl_wr;
    logic reload_req, update_req, erase_go, prog_go, op_done;
    logic [4:0] code;
    logic [6:0] manual_q;
    logic [6:0] init_q;

    assign acc_ok = !run && !ext_pwm_in;
    assign store_ready_out = acc_ok && state == ST_IDLE;
    assign sh_wr = wr_en_in && addr_in[7:5] == SHADOW_TAG && store_ready_out;
    assign store_wr = wr_en_in && addr_in == STORE_ADDR && state == ST_IDLE;
    assign ctrl_wr = wr_en_in && addr_in == CTRL_ADDR;
    assign update_req = store_wr && wdata_in[UPDATE_BIT] && wdata_in[RELOAD_BIT];
    assign reload_req = store_wr && wdata_in[RELOAD_BIT] && !wdata_in[UPDATE_BIT];
    // Erase and program act on the falling write, so a held 1 never repeats an erase
    assign erase_go = store_wr && st_erase && !wdata_in[ERASE_BIT];
    assign prog_go = store_wr && st_prog && !wdata_in[PROG_BIT];
    assign op_done = op_cnt == 16'(NVM_OP_CYCLES - 1);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_BOOT;
        end else begin
            unique case (state)
                ST_BOOT: state <= ST_IDLE;
                ST_IDLE: begin
                    if (erase_go) begin
                        state <= ST_ERASE;
                    end else if (prog_go) begin
                        state <= ST_PROG;
                    end
                end
                ST_ERASE, ST_PROG: begin
                    if (op_done) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_cnt <= '0;
        end else begin
            op_cnt <= (state == ST_IDLE || op_done) ? '0 : op_cnt + 16'h0001;
        end
    end

    // Storage keeps its contents across reset, as a real cell array would
    always_ff @(posedge mclk_in) begin
        if (op_done && state == ST_ERASE) begin
            for (int i = 0; i < 32; i++) begin
                nvm[i] <= NVM_ERASED;
            end
        end else if (op_done && state == ST_PROG && erased) begin
            for (int i = 0; i < 32; i++) begin
                nvm[i] <= shadow[i];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            erased <= 1'b0;
        end else if (op_done) begin
            erased <= state == ST_ERASE;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 32; i++) begin
                shadow[i] <= 8'h00;
                work[i] <= 8'h00;
            end
        end else if (state == ST_BOOT || reload_req) begin
            for (int i = 0; i < 32; i++) begin
                shadow[i] <= nvm[i];
                work[i] <= nvm[i];
            end
        end else if (update_req) begin
            for (int i = 0; i < 32; i++) begin
                if (has_work(5'(i))) begin
                    work[i] <= shadow[i];
                end
            end
        end else if (sh_wr) begin
            shadow[addr_in[4:0]] <= wdata_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {st_update, st_reload, st_prog, st_erase} <= 4'h0;
        end else if (store_wr) begin
            {st_update, st_reload, st_prog, st_erase} <= wdata_in[UPDATE_BIT:ERASE_BIT];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {adapt, boost_on, run} <= CTRL_RESET;
            boost_out <= BOOST_OUT_RESET;
        end else if (ctrl_wr) begin
            {adapt, boost_on, run} <= wdata_in[ADAPT_BIT:RUN_BIT];
        end else if (wr_en_in && addr_in == BOOST_OUT_ADDR) begin
            boost_out <= wdata_in[4:0];
        end
    end

    // New events win over the clear in the same cycle
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_stat <= 8'h00;
        end else begin
            fault_stat <= ((ctrl_wr && wdata_in[RUN_BIT]) ? 8'h00 : fault_stat) | fault_event_in;
        end
    end

    assign fault_pin_out = 1'b0;
    assign fault_pin_oe_out = |fault_stat;

    // Frequency decode
    assign code = {work[CFG_PWM_IDX][SEL_A_LSB+2:SEL_A_LSB], work[CFG_PWM_IDX][SHIFT_SEL_LSB+1:SHIFT_SEL_LSB]};

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_shift_pwm_out <= 1'b0;
            pwm_rate_hz_out <= '0;
            shift_rate_hz_out <= '0;
        end else begin
            phase_shift_pwm_out <= !work[CFG_PWM_IDX][SHIFT_DIS_BIT];
            if (work[CFG_PWM_IDX][SHIFT_DIS_BIT]) begin
                shift_rate_hz_out <= '0;
                pwm_rate_hz_out <= work[CFG_PWM_IDX][RATE_MODE_BIT] ? FREQ_W'(MODE1_OUT_HZ[code])
                    : FREQ_W'(MODE0_SHIFT_HZ[{code[4:2], 2'b00}]);
            end else if (work[CFG_PWM_IDX][RATE_MODE_BIT]) begin
                pwm_rate_hz_out <= FREQ_W'(MODE1_OUT_HZ[code]);
                shift_rate_hz_out <= FREQ_W'(MODE1_OUT_HZ[code] * N_STRINGS);
            end else begin
                shift_rate_hz_out <= FREQ_W'(MODE0_SHIFT_HZ[code]);
                pwm_rate_hz_out <= FREQ_W'(MODE0_SHIFT_HZ[code] / N_STRINGS);
            end
        end
    end

    // Thermal derating; reduction saturates so the output never wraps
    int deg_c, lim_c, red_c;
    always_comb begin
        deg_c = int'(temp_in >> TEMP_FRAC_BITS);
        lim_c = TEMP_LIMIT_C[work[CFG_TEMP_IDX][TEMP_LIMIT_SEL_LSB+1:TEMP_LIMIT_SEL_LSB]];
        red_c = 0;
        if (deg_c > lim_c) begin
            red_c = (deg_c - lim_c) * ((1 << PWM_W) - 1) * DERATE_PCT_PER_C / PCT_FULL;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            led_pwm_out <= '0;
        end else if (!chip_en_in) begin
            led_pwm_out <= led_pwm_in;
        end else begin
            led_pwm_out <= (red_c >= int'(led_pwm_in)) ? '0 : PWM_W'(int'(led_pwm_in) - red_c);
        end
    end

    // Boost control in quarter-volt codes above 10 V
    assign manual_q = {(boost_out > VOUT_MAX_CODE) ? VOUT_MAX_CODE : boost_out, 2'b00};
    assign init_q = (work[CFG_INIT_IDX][6:0] > ADAPT_MAX) ? ADAPT_MAX : work[CFG_INIT_IDX][6:0];
    assign boost_run_out = boost_on;
    assign boost_fast_out = work[CFG_PWM_IDX][BOOST_RATE_BIT];
    assign boost_vout_out = vq;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q <= 1'b0;
            adapt_q <= 1'b0;
        end else begin
            run_q <= boost_on;
            adapt_q <= adapt;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vq <= 7'h00;
        end else if (!boost_on || !adapt) begin
            vq <= manual_q;
        end else if (!run_q) begin
            vq <= init_q;
        end else if (!adapt_q) begin
            vq <= manual_q;
        end else if (boost_up_in && vq < ADAPT_MAX) begin
            vq <= vq + 7'h01;
        end else if (boost_down_in && !boost_up_in && vq != 7'h00) begin
            vq <= vq - 7'h01;
        end
    end

    // Low bits are frozen by the high read so the pair stays coherent
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            temp_lo <= '0;
        end else if (rd_en_in && addr_in == TEMP_HI_ADDR) begin
            temp_lo <= temp_in[TEMP_FRAC_BITS-1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_en_in) begin
            if (addr_in[7:5] == SHADOW_TAG) begin
                rdata_out <= store_ready_out ? shadow[addr_in[4:0]] : 8'h00;
            end else begin
                case (addr_in)
                    CTRL_ADDR: rdata_out <= {5'h00, adapt, boost_on, run};
                    FAULT_ADDR: rdata_out <= fault_stat;
                    BOOST_OUT_ADDR: rdata_out <= {3'h0, boost_out};
                    BOOST_INIT_ADDR: rdata_out <= work[CFG_INIT_IDX];
                    STORE_ADDR: rdata_out <= {store_ready_out, 3'h0, st_update, st_reload, st_prog, st_erase};
                    TEMP_HI_ADDR: rdata_out <= temp_in[TEMP_W-1:TEMP_FRAC_BITS];
                    TEMP_LO_ADDR: rdata_out <= {5'h00, temp_lo};
                    default: rdata_out <= 8'h00;
                endcase
            end
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    shadow_gate_a: assert property ((wr_en_in && addr_in == 8'ha1 && !store_ready_out && state == ST_IDLE) |=> shadow[1] == $past(shadow[1])) else $error("shadow written while locked");
    ready_lock_a: assert property ((run || ext_pwm_in) |-> !store_ready_out) else $error("store ready while running");
    noreg_now_a: assert property ((sh_wr && addr_in == 8'ha5) |=> shadow[5] == $past(wdata_in)) else $error("direct byte not written");
    update_copy_a: assert property (update_req |=> work[CFG_PWM_IDX] == $past(shadow[CFG_PWM_IDX])) else $error("update lost");
    hold_work_a: assert property ((sh_wr && !update_req && !reload_req) |=> $stable(work[CFG_PWM_IDX])) else $error("working byte changed early");
    reload_copy_a: assert property (reload_req |=> shadow[CFG_INIT_IDX] == $past(nvm[CFG_INIT_IDX])) else $error("reload lost");
    erase_run_a: assert property ((erase_go && state == ST_IDLE) |=> state == ST_ERASE ##(NVM_OP_CYCLES) state == ST_IDLE) else $error("erase timing wrong");
    mode1_rate_a: assert property ((!work[CFG_PWM_IDX][SHIFT_DIS_BIT] && work[CFG_PWM_IDX][RATE_MODE_BIT]) |=> shift_rate_hz_out == FREQ_W'(pwm_rate_hz_out * N_STRINGS)) else $error("shift rate not N times output");
    derate_zero_a: assert property ((chip_en_in && deg_c >= lim_c + 25) |=> led_pwm_out == '0) else $error("derating did not reach zero");
    fault_clear_a: assert property ((ctrl_wr && wdata_in[RUN_BIT] && fault_event_in == 8'h00) |=> !fault_pin_oe_out) else $error("fault not released");
    manual_clamp_a: assert property (!boost_on |=> vq == {(($past(boost_out) > VOUT_MAX_CODE) ? VOUT_MAX_CODE : $past(boost_out)), 2'b00}) else $error("manual voltage wrong");
    adapt_start_a: assert property ((boost_on && adapt && !run_q) |=> vq == $past(init_q)) else $error("adaptive start value wrong");

    reload_seen_c: cover property (reload_req ##1 store_ready_out);
    adapt_step_c: cover property (boost_on && adapt && run_q && adapt_q && boost_up_in);
    derate_c: cover property (chip_en_in && red_c > 0 && red_c < int'(led_pwm_in));
    program_c: cover property (state == ST_PROG && op_done && erased);
endmodule

// ### rtl/bl_cfg_pkg.sv
// Constants, tables and types for the backlight configuration store
package bl_cfg_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] FAULT_ADDR = 8'h01;
    localparam logic [7:0] BOOST_OUT_ADDR = 8'h07;
    localparam logic [7:0] BOOST_INIT_ADDR = 8'h29;
    localparam logic [7:0] STORE_ADDR = 8'h72;
    localparam logic [7:0] TEMP_HI_ADDR = 8'h78;
    localparam logic [7:0] TEMP_LO_ADDR = 8'h79;
    localparam logic [2:0] SHADOW_TAG = 3'h5;
    localparam int RUN_BIT = 0;
    localparam int BOOST_ON_BIT = 1;
    localparam int ADAPT_BIT = 2;
    localparam int ERASE_BIT = 0;
    localparam int PROG_BIT = 1;
    localparam int RELOAD_BIT = 2;
    localparam int UPDATE_BIT = 3;
    localparam int READY_BIT = 7;
    localparam logic [4:0] CFG_PWM_IDX = 5'h1c;
    localparam logic [4:0] CFG_INIT_IDX = 5'h1d;
    localparam logic [4:0] CFG_TEMP_IDX = 5'h1e;
    localparam int SEL_A_LSB = 0;
    localparam int SHIFT_SEL_LSB = 3;
    localparam int RATE_MODE_BIT = 5;
    localparam int SHIFT_DIS_BIT = 6;
    localparam int BOOST_RATE_BIT = 7;
    localparam int TEMP_LIMIT_SEL_LSB = 0;
    localparam logic [4:0] NOREG_A_LO = 5'h00;
    localparam logic [4:0] NOREG_A_HI = 5'h0f;
    localparam logic [4:0] NOREG_B_LO = 5'h14;
    localparam logic [4:0] NOREG_B_HI = 5'h1b;
    localparam logic [2:0] CTRL_RESET = 3'h4;
    localparam logic [4:0] BOOST_OUT_RESET = 5'h00;
    localparam logic [7:0] NVM_ERASED = 8'h00;
    localparam logic [4:0] VOUT_MAX_CODE = 5'h1c;
    localparam logic [6:0] ADAPT_MAX = 7'h70;
    localparam int TEMP_W = 11;
    localparam int TEMP_FRAC_BITS = 3;
    localparam int DERATE_PCT_PER_C = 4;
    localparam int PCT_FULL = 100;
    localparam int TEMP_LIMIT_C [4] = '{100, 110, 120, 130};
    localparam int FREQ_W = 18;
    localparam int MODE0_SHIFT_HZ [32] = '{992, 496, 248, 124, 1526, 763, 382, 191,
        1983, 993, 496, 248, 2441, 1221, 610, 305, 2974, 1487, 744, 372,
        3965, 1983, 991, 496, 4883, 2441, 1221, 610, 19531, 9766, 4883, 2441};
    localparam int MODE1_OUT_HZ [32] = '{229, 305, 381, 458, 534, 610, 687, 763,
        839, 916, 992, 1068, 1144, 1221, 1297, 1373, 1450, 1526, 1602, 1678,
        1755, 1831, 1908, 1983, 2060, 2671, 3203, 3737, 4270, 4808, 9766, 19531};
    typedef enum logic [3:0] {
        ST_BOOT = 4'b0001,
        ST_IDLE = 4'b0010,
        ST_ERASE = 4'b0100,
        ST_PROG = 4'b1000
    } store_state_t;
endpackage

// ### verif/host_model.sv
// Host model driving the register port of the configuration store
`timescale 1ns/100ps
module host_model
    import bl_cfg_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [7:0] rdata_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    initial begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // Released lines show the inverse so a stale value never looks valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1 wr_en_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(posedge mclk_in);
        #1 wr_en_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1 rd_en_out = 1'b1;
        addr_out = a;
        @(posedge mclk_in);
        #1 rd_en_out = 1'b0;
        addr_out = ~a;
        d = rdata_in;
    endtask
    // Set then clear: erase and program need the zero written back; update and reload act on the set write
    task automatic store_cmd(input logic [7:0] c);
        write_reg(STORE_ADDR, c);
        write_reg(STORE_ADDR, 8'h00);
    endtask
    task automatic read_temp(output logic [7:0] hi, output logic [7:0] lo);
        read_reg(TEMP_HI_ADDR, hi);
        read_reg(TEMP_LO_ADDR, lo);
    endtask
endmodule

// ### verif/tb_backlight_config_and_boost_ctrl.sv
// Self-checking bench for the backlight configuration store
`timescale 1ns/100ps
module tb_backlight_config_and_boost_ctrl;
    import bl_cfg_pkg::*;
    localparam int N_STR = 7;
    logic mclk_in, rst_n_in, wr_en, rd_en, ext_pwm_in, chip_en_in, fault_pin_out, fault_pin_oe_out;
    logic boost_up_in, boost_down_in, boost_run_out, boost_fast_out, phase_shift_pwm_out, store_ready_out;
    logic [7:0] addr, wdata, rdata_out, led_pwm_in, led_pwm_out, fault_event_in, d, b, hi, lo;
    logic [10:0] temp_in;
    logic [6:0] boost_vout_out;
    logic [17:0] pwm_rate_hz_out, shift_rate_hz_out;
    logic [35:0] expr;
    logic [7:0] shadow [32];
    int err_count, samples_checked, cycles, i, k, t;
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    host_model u_host (.mclk_in(mclk_in), .rdata_in(rdata_out), .wr_en_out(wr_en), .rd_en_out(rd_en),
        .addr_out(addr), .wdata_out(wdata));
    backlight_config_and_boost_ctrl #(.N_STRINGS(N_STR), .PWM_W(8), .NVM_OP_CYCLES(4)) u_dut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
        .wdata_in(wdata), .rdata_out(rdata_out), .ext_pwm_in(ext_pwm_in), .chip_en_in(chip_en_in),
        .temp_in(temp_in), .led_pwm_in(led_pwm_in), .led_pwm_out(led_pwm_out),
        .fault_event_in(fault_event_in), .fault_pin_out(fault_pin_out), .fault_pin_oe_out(fault_pin_oe_out),
        .boost_up_in(boost_up_in), .boost_down_in(boost_down_in), .boost_run_out(boost_run_out),
        .boost_fast_out(boost_fast_out), .boost_vout_out(boost_vout_out),
        .phase_shift_pwm_out(phase_shift_pwm_out), .pwm_rate_hz_out(pwm_rate_hz_out),
        .shift_rate_hz_out(shift_rate_hz_out), .store_ready_out(store_ready_out));
    task automatic check(input string n, input logic [35:0] e, input logic [35:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %0h, seen %0h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    task automatic do_reset();
        #1 rst_n_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        repeat (2) @(posedge mclk_in);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (store_ready_out !== 1'b1 && n < 100) begin
            @(posedge mclk_in);
            #1 n++;
        end
        check("store_ready", 1, store_ready_out);
    endtask
    task automatic scramble_readback(input logic rst);
        for (int j = 0; j < 32; j++) u_host.write_reg(8'ha0 + 8'(j), ~shadow[j]);
        if (rst) do_reset();
        else u_host.store_cmd(8'h04);
        for (int j = 0; j < 32; j++) begin
            u_host.read_reg(8'ha0 + 8'(j), d);
            check("shadow", shadow[j], d);
        end
    endtask
    // Rate decode worked out from the frequency tables and the mode bits
    function automatic logic [35:0] rates(input logic [7:0] v);
        logic [4:0] c;
        int p, s;
        c = {v[2:0], v[4:3]};
        s = v[5] ? MODE1_OUT_HZ[c] * N_STR : MODE0_SHIFT_HZ[c];
        p = v[5] ? MODE1_OUT_HZ[c] : (v[6] ? MODE0_SHIFT_HZ[{c[4:2], 2'b00}] : s / N_STR);
        if (v[6]) s = 0;
        return {18'(p), 18'(s)};
    endfunction
    function automatic logic [7:0] derate(input logic [7:0] v, input logic [10:0] tt, input logic [1:0] l);
        int o, r;
        o = int'(tt[10:3]) - TEMP_LIMIT_C[l];
        r = (o > 0) ? o * 255 * 4 / 100 : 0;
        return (r >= int'(v)) ? 8'h00 : 8'(int'(v) - r);
    endfunction
    initial begin
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        rst_n_in = 1'b0;
        {ext_pwm_in, chip_en_in, boost_up_in, boost_down_in} = 4'h0;
        {temp_in, led_pwm_in, fault_event_in} = 27'h0;
        void'($urandom(32'h0e74));
        do_reset();
        #1 check("ready after boot", 1, store_ready_out);
        u_host.read_reg(CTRL_ADDR, d);
        check("ctrl reset", 8'h04, d);
        for (i = 0; i < 32; i++) begin
            shadow[i] = 8'($urandom);
            u_host.write_reg(8'ha0 + 8'(i), shadow[i]);
        end
        u_host.store_cmd(8'h01);
        check("ready while erasing", 0, store_ready_out);
        wait_ready();
        u_host.store_cmd(8'h02);
        check("ready while programming", 0, store_ready_out);
        wait_ready();
        scramble_readback(1'b1);
        scramble_readback(1'b0);
        expr = rates(shadow[28]);
        for (i = 0; i < 32; i++) begin
            b = {1'($urandom), i[3:2], i[4:0]};
            u_host.write_reg(8'hbc, b);
            repeat (3) @(posedge mclk_in);
            #1 check("rate before update", expr, {pwm_rate_hz_out, shift_rate_hz_out});
            u_host.store_cmd(8'h0c);
            repeat (3) @(posedge mclk_in);
            expr = rates(b);
            #1 check("rates", expr, {pwm_rate_hz_out, shift_rate_hz_out});
            check("phase shift", !b[6], phase_shift_pwm_out);
            check("boost rate", b[7], boost_fast_out);
        end
        for (i = 0; i < 4; i++) begin
            u_host.write_reg(8'hbe, 8'(i));
            u_host.store_cmd(8'h0c);
            for (k = 0; k < 8; k++) begin
                t = TEMP_LIMIT_C[i] - 3 + ((k == 0) ? 27 : int'($urandom % 32));
                temp_in = {8'(t), 3'($urandom)};
                led_pwm_in = (k == 0) ? 8'hff : 8'($urandom);
                chip_en_in = (k < 6);
                ext_pwm_in = 1'($urandom);
                repeat (3) @(posedge mclk_in);
                #1 check("derated pwm", chip_en_in ? derate(led_pwm_in, temp_in, 2'(i)) : led_pwm_in,
                    led_pwm_out);
                check("ready with pin", !ext_pwm_in, store_ready_out);
            end
            ext_pwm_in = 1'b0;
        end
        u_host.read_temp(hi, lo);
        check("temperature high", temp_in[10:3], hi);
        check("temperature low", {5'h00, temp_in[2:0]}, lo);
        u_host.write_reg(CTRL_ADDR, 8'h00);
        for (i = 26; i < 32; i++) begin
            u_host.write_reg(BOOST_OUT_ADDR, 8'(i));
            repeat (2) @(posedge mclk_in);
            #1 check("manual vout", ((i > 28) ? 28 : i) * 4, boost_vout_out);
            check("boost idle", 0, boost_run_out);
        end
        u_host.write_reg(BOOST_OUT_ADDR, 8'h05);
        u_host.write_reg(CTRL_ADDR, 8'h02);
        u_host.write_reg(CTRL_ADDR, 8'h06);
        check("boost running", 1, boost_run_out);
        @(posedge mclk_in);
        #1 check("adaptive start", 20, boost_vout_out);
        boost_up_in = 1'b1;
        repeat (3) @(posedge mclk_in);
        #1 boost_up_in = 1'b0;
        boost_down_in = 1'b1;
        @(posedge mclk_in);
        #1 boost_down_in = 1'b0;
        @(posedge mclk_in);
        #1 check("adaptive steps", 22, boost_vout_out);
        // Random trims; up wins, the code stays within 0 to 112
        t = 22;
        for (k = 0; k < 16; k++) begin
            {boost_up_in, boost_down_in} = 2'($urandom);
            @(posedge mclk_in);
            if (boost_up_in) t = (t < 112) ? t + 1 : t;
            else if (boost_down_in && t > 0) t = t - 1;
            #1 check("random steps", t, boost_vout_out);
        end
        {boost_up_in, boost_down_in} = 2'h0;
        u_host.write_reg(CTRL_ADDR, 8'h00);
        u_host.write_reg(CTRL_ADDR, 8'h06);
        @(posedge mclk_in);
        #1 check("stored start", (shadow[29][6:0] > 112) ? 112 : shadow[29][6:0], boost_vout_out);
        ext_pwm_in = 1'b1;
        u_host.write_reg(8'ha1, ~shadow[1]);
        check("ready locked", 0, store_ready_out);
        u_host.read_reg(8'ha1, d);
        check("locked read", 0, d);
        ext_pwm_in = 1'b0;
        u_host.read_reg(8'ha1, d);
        check("unchanged shadow", shadow[1], d);
        fault_event_in = 8'($urandom) | 8'h01;
        b = fault_event_in;
        @(posedge mclk_in);
        #1 fault_event_in = 8'h00;
        repeat (2) @(posedge mclk_in);
        #1 check("fault pin", 1, fault_pin_oe_out);
        check("fault pin level", 0, fault_pin_out);
        u_host.read_reg(FAULT_ADDR, d);
        check("fault status", b, d);
        u_host.write_reg(CTRL_ADDR, 8'h01);
        check("ready while running", 0, store_ready_out);
        @(posedge mclk_in);
        #1 check("fault released", 0, fault_pin_oe_out);
        u_host.read_reg(FAULT_ADDR, d);
        check("fault cleared", 0, d);
        u_host.read_reg(8'h55, d);
        check("unmapped", 0, d);
        conclude();
    end
endmodule
